// file: design/den_timing_pkg.sv
// Purpose: shared constants and carrier types of the data-enable panel timing block.
// Assumes: 16-bit RGB565 pixels, 24-bit SDRAM word addresses, 25 MHz system clock.
// Notes: panel geometry and minimum blanking are fixed; the frame pacing count is derived here.
package den_timing_pkg;

    localparam int unsigned PIXEL_W = 16;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned FIFO_DEPTH = 8;

    localparam logic [9:0] H_ACTIVE_PX = 10'h1e0;
    localparam logic [8:0] V_ACTIVE_LINES = 9'h110;
    localparam logic [8:0] H_BLANK_MIN = 9'h02d;
    localparam logic [7:0] V_BLANK_MIN = 8'h0d;
    localparam logic [16:0] FRAME_WORDS = 17'h1fe00;

    localparam logic [PIXEL_W-1:0] PIXEL_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic SYNC_INACTIVE = 1'b1;

    localparam int unsigned CLK_FREQ_MHZ = 25;
    localparam int unsigned FRAME_PERIOD_US = 16000;
    localparam int unsigned FRAME_CYCLES_DEF = FRAME_PERIOD_US * CLK_FREQ_MHZ;

    typedef logic [PIXEL_W-1:0] pixel_t;
    typedef logic [ADDR_W-1:0] addr_t;

    typedef struct packed {
        logic [8:0] h_blank;
        logic [7:0] v_blank_lines;
        addr_t fb_base;
    } timing_cfg_t;

    localparam timing_cfg_t CFG_RST = '{h_blank: 9'h02d, v_blank_lines: 8'h0d, fb_base: 24'h000000};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_VBLANK = 3'b001,
        ST_PRIME = 3'b011,
        ST_ACTIVE = 3'b010,
        ST_HBLANK = 3'b110
    } den_state_t;

endpackage

// file: design/pixel_fifo.sv
// Purpose: small synchronous FIFO between the SDRAM fetch and the pixel output.
// Assumes: one clock, valid/ready on both sides.
// Notes: in_ready is honest; a full FIFO stalls the fetch logic.
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;

    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = (count_reg != DEPTH_CNT);
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem[rd_ptr_reg];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

// file: design/dot_clock_sampler.sv
// Purpose: bring the dot clock pin into the system clock domain and mark its falling edges.
// Assumes: system clock at least four times the dot clock.
// Notes: the tick lags the pin edge by two to three system clocks.
`timescale 1ns/1ps
module dot_clock_sampler (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dot_clk_i,
    output logic dot_fall_o
);

    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;

    // The first stage feeds only the second; the edge is taken between stages two and three.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg <= 1'b0;
            dot_fall_o <= 1'b0;
        end else begin
            sync1_reg <= dot_clk_i;
            sync2_reg <= sync1_reg;
            last_reg <= sync2_reg;
            dot_fall_o <= last_reg && !sync2_reg;
        end
    end

endmodule

// file: design/den_lcd_timing.sv
// Purpose: data-enable mode timing and pixel streaming for a 480x272 panel without memory.
// Assumes: SDRAM read port and processor grant on clk_i; dot clock arrives on a pin.
// Notes: outputs change on the falling dot edge so the panel samples them on the rising one.
// Function
// - Frame and line sync held inactive always.
// - Line valid high only while pixels clock.
// - At least 45 idle dots between lines.
// - Each valid line carries exactly 480 pixels.
// - Thirteen or more blank lines mark frames.
// - 272 lines per frame, top to bottom.
// - Frames repeat no sooner than every 16 ms.
// - Painting most of the frame, rest free blanking.
// - Pixels leave exactly at dot clock rate.
// - Pixels fetched from selectable SDRAM frame buffer.
// - No processor SDRAM access while painting.
// - Processor may use SDRAM during blanking.
// - Grant lock makes processor wait painting.
// - Pixels are 16-bit RGB565 words.
// - Stream runs without break once started.
`timescale 1ns/1ps
module den_lcd_timing
    import den_timing_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dot_clk_i,
    input wire logic cfg_valid_i,
    input wire timing_cfg_t cfg_i,
    output logic mem_rd_o,
    output addr_t mem_addr_o,
    input wire logic mem_ack_i,
    input wire pixel_t mem_rdata_i,
    input wire logic cpu_req_i,
    output logic cpu_grant_o,
    output logic line_data_valid_o,
    output pixel_t pixel_o,
    output logic hsync_n_o,
    output logic vsync_n_o,
    output logic painting_o,
    output logic frame_start_o,
    output logic underrun_o
);

    localparam logic [19:0] FRAME_LAST = 20'(FRAME_CYCLES - 1);

    // The pacing timer only sets a floor on the frame period.
    // The dot clock and the blanking figures set the rest.
    // A short FRAME_CYCLES lets a bench reach the first frame quickly.

    ////////////////////////////////////////////////////////////////////////////////
    // State and counters.

    den_state_t state_reg;
    den_state_t state_next;
    logic [9:0] x_reg;
    logic [9:0] x_next;
    logic [8:0] line_reg;
    logic [8:0] line_next;
    logic [7:0] vcnt_reg;
    logic [7:0] vcnt_next;
    logic configured_reg;
    timing_cfg_t cfg_reg;
    logic [19:0] frame_timer_reg;
    logic [16:0] fetch_left_reg;
    addr_t fetch_addr_reg;
    logic rd_pending_reg;

    // Handshake wires between the dot sampler, the fetch and the FIFO.
    wire dot_tick;
    wire fifo_in_ready;
    wire fifo_out_valid;
    pixel_t fifo_out_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Dot clock crossing.

    // The pin is sampled twice before any logic reads it.
    // The resulting tick is a one-clock pulse per falling dot edge.
    // The state machine and its dot counters advance only on that tick, so the clock ratio must stay at four or above.
    dot_clock_sampler u_sampler (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .dot_clk_i(dot_clk_i),
        .dot_fall_o(dot_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding.

    // One line lasts the active pixels plus the configured gap.
    // Blank lines reuse the same length so the panel sees a steady line rate.
    wire [9:0] line_len = H_ACTIVE_PX + {1'b0, cfg_reg.h_blank};
    wire line_end = (x_reg == line_len - 10'h001);
    wire active_end = (x_reg == H_ACTIVE_PX - 10'h001);
    wire hblank_end = (x_reg == {1'b0, cfg_reg.h_blank} - 10'h001);
    wire last_line = (line_reg == V_ACTIVE_LINES - 9'h001);
    wire vlines_done = (vcnt_reg + 8'h01 >= cfg_reg.v_blank_lines);
    wire frame_elapsed = (frame_timer_reg == FRAME_LAST);
    wire frame_due = vlines_done && frame_elapsed;
    wire painting_state = (state_reg == ST_PRIME) || (state_reg == ST_ACTIVE)
                          || (state_reg == ST_HBLANK);
    // enter_prime fires on the tick that moves the machine into prime; enter_active fires on every tick whose next state is active.
    // They restart the fetch and pop the FIFO in step with the outputs.
    wire enter_prime = dot_tick && (state_next == ST_PRIME) && (state_reg != ST_PRIME);
    wire enter_active = dot_tick && (state_next == ST_ACTIVE);
    wire fetch_issue = painting_state && (fetch_left_reg != '0) && !rd_pending_reg
                       && fifo_in_ready;
    wire fifo_push = mem_ack_i && rd_pending_reg;
    wire fifo_pop = enter_active && fifo_out_valid;
    wire lock_next = painting_state || (state_reg == ST_VBLANK && frame_due);

    // Clamp keeps a careless configuration from breaking the panel's minimum blanking.
    // Values below the minimum are raised, never refused.
    wire [8:0] h_blank_cl = (cfg_i.h_blank < H_BLANK_MIN) ? H_BLANK_MIN : cfg_i.h_blank;
    wire [7:0] v_lines_cl = (cfg_i.v_blank_lines < V_BLANK_MIN) ? V_BLANK_MIN
                            : cfg_i.v_blank_lines;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing state machine.

    // Next-state logic. Counters hold unless their state moves them.
    // Only the tick lets the registers below take these values.
    always_comb begin
        state_next = state_reg;
        x_next = x_reg;
        line_next = line_reg;
        vcnt_next = vcnt_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (configured_reg) begin
                    state_next = ST_VBLANK;
                    x_next = '0;
                    vcnt_next = '0;
                end
            end
            ST_VBLANK: begin
                x_next = x_reg + 10'h001;
                if (line_end) begin
                    x_next = '0;
                    if (!vlines_done) begin
                        vcnt_next = vcnt_reg + 8'h01;
                    end
                    if (frame_due) begin
                        state_next = ST_PRIME;
                    end
                end
            end
            // The priming line is blank as well; it fills the FIFO ahead of line 0.
            ST_PRIME: begin
                x_next = x_reg + 10'h001;
                if (line_end) begin
                    state_next = ST_ACTIVE;
                    x_next = '0;
                    line_next = '0;
                end
            end
            ST_ACTIVE: begin
                x_next = x_reg + 10'h001;
                if (active_end) begin
                    state_next = ST_HBLANK;
                    x_next = '0;
                end
            end
            ST_HBLANK: begin
                x_next = x_reg + 10'h001;
                if (hblank_end) begin
                    x_next = '0;
                    if (last_line) begin
                        state_next = ST_VBLANK;
                        vcnt_next = '0;
                    end else begin
                        state_next = ST_ACTIVE;
                        line_next = line_reg + 9'h001;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                x_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            x_reg <= '0;
            line_reg <= '0;
            vcnt_reg <= '0;
        end else if (dot_tick) begin
            state_reg <= state_next;
            x_reg <= x_next;
            line_reg <= line_next;
            vcnt_reg <= vcnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and frame pacing.

    // Configuration is accepted once after reset; a new geometry needs a new reset.
    // Blanking figures are taken only while idle; the buffer base is taken per frame.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            configured_reg <= 1'b0;
            cfg_reg <= CFG_RST;
        end else if (state_reg == ST_IDLE && cfg_valid_i && !configured_reg) begin
            configured_reg <= 1'b1;
            cfg_reg.h_blank <= h_blank_cl;
            cfg_reg.v_blank_lines <= v_lines_cl;
            cfg_reg.fb_base <= cfg_i.fb_base;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_timer_reg <= '0;
        end else if (enter_prime) begin
            frame_timer_reg <= '0;
        end else if (!frame_elapsed) begin
            frame_timer_reg <= frame_timer_reg + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SDRAM fetch.

    // Addresses run consecutively from the base, one word per pixel, top line first.
    // The base is read live at each prime, so software can flip buffers between frames.
    // One read is in flight at a time, and only with room in the FIFO, so a push never stalls.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fetch_left_reg <= '0;
            fetch_addr_reg <= ADDR_RST;
            rd_pending_reg <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_addr_o <= ADDR_RST;
        end else begin
            if (enter_prime) begin
                fetch_addr_reg <= cfg_i.fb_base;
                fetch_left_reg <= FRAME_WORDS;
            end else if (fetch_issue) begin
                fetch_addr_reg <= fetch_addr_reg + 24'h000001;
                fetch_left_reg <= fetch_left_reg - 17'h00001;
            end
            if (fetch_issue) begin
                rd_pending_reg <= 1'b1;
                mem_rd_o <= 1'b1;
                mem_addr_o <= fetch_addr_reg;
            end else if (fifo_push) begin
                rd_pending_reg <= 1'b0;
                mem_rd_o <= 1'b0;
            end
        end
    end

    // The FIFO hides SDRAM latency from the panel.
    // Eight words cover a full dot period of worst-case read delay with room to spare.
    // Reads are fetched ahead during the priming line, so the first pixel is ready.
    pixel_fifo #(
        .WIDTH(PIXEL_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mem_rdata_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Panel outputs.

    // Valid and pixel change only on a tick, three to four system clocks after the falling dot edge.
    // An empty FIFO sends black and sets a sticky flag rather than stalling the line.

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_data_valid_o <= 1'b0;
            pixel_o <= PIXEL_RST;
            frame_start_o <= 1'b0;
            underrun_o <= 1'b0;
        end else begin
            frame_start_o <= dot_tick && (state_reg == ST_PRIME) && (state_next == ST_ACTIVE);
            if (dot_tick) begin
                line_data_valid_o <= (state_next == ST_ACTIVE);
                pixel_o <= fifo_pop ? fifo_out_data : PIXEL_RST;
            end
            if (enter_active && !fifo_out_valid) begin
                underrun_o <= 1'b1;
            end
        end
    end

    // Sync pins are registered constants so they come from flip-flops like every output.
    // A panel in data-enable mode ignores them, but a floating level could confuse it.
    // syncs held inactive
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hsync_n_o <= SYNC_INACTIVE;
            vsync_n_o <= SYNC_INACTIVE;
        end else begin
            hsync_n_o <= SYNC_INACTIVE;
            vsync_n_o <= SYNC_INACTIVE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Processor access lock.

    // The processor side sees only a level grant, one clock after its request.
    // Software that waits on it must tolerate a stall of a whole painting interval.
    // A request held across painting is answered as soon as the lock opens again.

    // The grant drops when frame_due is reached in the last blank line, ahead of the priming line, so a running access can finish in time.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            painting_o <= 1'b0;
            cpu_grant_o <= 1'b0;
        end else begin
            painting_o <= lock_next;
            cpu_grant_o <= cpu_req_i && !lock_next;
        end
    end

endmodule

// file: testbench/sdram_read_model.sv
// Purpose: behavioural SDRAM read port behind the pixel fetch.
// Assumes: one read outstanding, answered on clk_i.
// Notes: latency follows the low address bits; idle data toggles every cycle.
`timescale 1ns/1ps
module sdram_read_model
    import den_timing_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mem_rd_i,
    input wire addr_t mem_addr_i,
    output logic mem_ack_o,
    output pixel_t mem_rdata_o
);
    logic [2:0] wait_reg;
    logic hit;
    assign hit = mem_rd_i && !mem_ack_o && wait_reg == {1'b0, mem_addr_i[1:0]};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_reg <= 3'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 16'h0000;
        end else if (hit) begin
            wait_reg <= 3'h0;
            mem_ack_o <= 1'b1;
            mem_rdata_o <= mem_addr_i[15:0] ^ 16'h5a3c;
        end else begin
            wait_reg <= (mem_rd_i && !mem_ack_o) ? wait_reg + 3'h1 : 3'h0;
            mem_ack_o <= 1'b0;
            // Stale data is inverted so a late capture cannot pass by luck.
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule

// file: testbench/den_lcd_timing_chk.sv
// Purpose: port checks of the data-enable panel timing block.
// Assumes: dot clock at most a quarter of clk_i.
// Notes: dot edges are re-sampled here so dot counts do not lean on the design.
`timescale 1ns/1ps
module den_lcd_timing_chk
    import den_timing_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dot_clk_i,
    input wire logic cpu_req_i,
    input wire logic cpu_grant_o,
    input wire logic mem_rd_o,
    input wire addr_t mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic line_data_valid_o,
    input wire pixel_t pixel_o,
    input wire logic hsync_n_o,
    input wire logic vsync_n_o,
    input wire logic painting_o,
    input wire logic frame_start_o
);
    ////////////////////////////////////////
    logic [1:0] dot_reg;
    logic [15:0] on_reg;
    logic [15:0] off_reg;
    logic fall;
    assign fall = dot_reg[1] & ~dot_reg[0];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dot_reg <= 2'h0;
            on_reg <= 16'h0000;
            off_reg <= 16'h0000;
        end else begin
            dot_reg <= {dot_reg[0], dot_clk_i};
            on_reg <= line_data_valid_o ? on_reg + {15'h0000, fall} : 16'h0000;
            off_reg <= line_data_valid_o ? 16'h0000 : off_reg + {15'h0000, fall};
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sync_idle_a: assert property (hsync_n_o && vsync_n_o)
        else $error("sync output active");
    blank_pixel_a: assert property (!line_data_valid_o |-> pixel_o == PIXEL_RST)
        else $error("pixel not zero outside line");
    line_length_a: assert property ($fell(line_data_valid_o) |-> on_reg == 16'h01e0)
        else $error("line not 480 dots");
    line_gap_a: assert property ($rose(line_data_valid_o) |-> off_reg >= 16'h002d)
        else $error("line gap under 45 dots");
    frame_gap_a: assert property (frame_start_o |-> off_reg >= 16'h1aa9)
        else $error("frame gap under 13 lines");
    first_pixel_a: assert property (frame_start_o |-> $rose(line_data_valid_o)
        ##1 !frame_start_o)
        else $error("frame start not with first pixel");
    valid_locked_a: assert property (line_data_valid_o |-> painting_o)
        else $error("line valid outside lock");
    paint_lock_a: assert property (painting_o && $past(painting_o) |-> !cpu_grant_o)
        else $error("grant while painting");
    free_grant_a: assert property ($past(rst_n_i) && $past(cpu_req_i) && !painting_o
        && !$past(painting_o) && !$past(painting_o, 2) |-> cpu_grant_o)
        else $error("no grant in blanking");
    grant_cause_a: assert property (cpu_grant_o |-> $past(cpu_req_i))
        else $error("grant without request");
    read_hold_a: assert property (mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o))
        else $error("read dropped or moved before ack");
    read_end_a: assert property (mem_rd_o && mem_ack_i |=> !mem_rd_o)
        else $error("read held after ack");
    cover property (frame_start_o);
    cover property ($fell(line_data_valid_o));
    cover property (cpu_req_i && cpu_grant_o);
endmodule
bind den_lcd_timing den_lcd_timing_chk i_den_lcd_timing_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .dot_clk_i(dot_clk_i), .cpu_req_i(cpu_req_i), .cpu_grant_o(cpu_grant_o), .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .line_data_valid_o(line_data_valid_o),
    .pixel_o(pixel_o), .hsync_n_o(hsync_n_o), .vsync_n_o(vsync_n_o), .painting_o(painting_o),
    .frame_start_o(frame_start_o));

// file: testbench/den_lcd_timing_test.sv
// Purpose: self-checking bench of the panel timing block.
// Assumes: 25 MHz clk, free 320 ns dot clock of unrelated phase.
// Notes: the frame timer is shortened; only the first three lines are scored.
`timescale 1ns/1ps
module den_lcd_timing_test
    import den_timing_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic dot_clk = 1'b0;
    logic cfg_valid = 1'b0;
    timing_cfg_t cfg = CFG_RST;
    logic mem_rd, mem_ack, cpu_grant, line_valid, hsync_n, vsync_n, painting, frame_start;
    logic underrun;
    logic cpu_req = 1'b0;
    addr_t mem_addr;
    pixel_t mem_rdata, pixel;
    pixel_t exp_q[$];
    logic [15:0] lfsr = 16'h004c;
    int fails = 0;
    int n_compared = 0;
    int waited;
    always #20 clk = ~clk;
    initial begin
        #13;
        forever #160 dot_clk = ~dot_clk;
    end
    den_lcd_timing #(.FRAME_CYCLES(2000)) i_den_lcd_timing (.clk_i(clk), .rst_n_i(rst_n),
        .dot_clk_i(dot_clk), .cfg_valid_i(cfg_valid), .cfg_i(cfg), .mem_rd_o(mem_rd),
        .mem_addr_o(mem_addr), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .cpu_req_i(cpu_req),
        .cpu_grant_o(cpu_grant), .line_data_valid_o(line_valid), .pixel_o(pixel),
        .hsync_n_o(hsync_n), .vsync_n_o(vsync_n), .painting_o(painting),
        .frame_start_o(frame_start), .underrun_o(underrun));
    sdram_read_model i_sdram_read_model (.clk_i(clk), .rst_n_i(rst_n), .mem_rd_i(mem_rd),
        .mem_addr_i(mem_addr), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));
    ////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check_bit(input logic act, input logic exp, input string what);
        n_compared++;
        if (act !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s is %b", $time, what, act);
        end
    endtask
    task automatic check_pix(input pixel_t act, input pixel_t exp);
        n_compared++;
        if (act !== exp) begin
            fails++;
            $display("MISMATCH at %0t: pixel %h, expected %h", $time, act, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Counts: %0d compared, %0d failed", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Panel side: takes each pixel well after the output settles.
    initial begin
        forever begin
            @(posedge dot_clk);
            repeat (2) @(negedge clk);
            if (line_valid === 1'b1 && exp_q.size() > 0) begin
                check_pix(pixel, exp_q.pop_front());
            end
        end
    end
    initial begin
        #(100000 * 40);
        fails++;
        $display("MISMATCH at %0t: run timed out", $time);
        tally_and_finish();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (2000) @(negedge clk);
        check_bit(line_valid, 1'b0, "valid before config");
        check_bit(painting, 1'b0, "lock before config");
        $display("test idle_until_config done");
        lfsr = lfsr_next(lfsr);
        // Blank settings below the minimum must be raised to it.
        cfg = '{h_blank: 9'h00a, v_blank_lines: 8'h05, fb_base: {8'h00, lfsr}};
        for (int i = 0; i < 1440; i++) begin
            exp_q.push_back((cfg.fb_base[15:0] + 16'(i)) ^ 16'h5a3c);
        end
        cfg_valid = 1'b1;
        @(negedge clk);
        cfg_valid = 1'b0;
        cpu_req = 1'b1;
        repeat (40) @(negedge clk);
        check_bit(cpu_grant, 1'b1, "grant in blanking");
        waited = 0;
        while (frame_start !== 1'b1 && waited < 70000) begin
            @(negedge clk);
            lfsr = lfsr_next(lfsr);
            cpu_req = lfsr[0];
            waited++;
        end
        check_bit(frame_start, 1'b1, "frame start");
        check_bit(waited >= 54600, 1'b1, "blank lines before frame");
        $display("test blank_then_frame done");
        cpu_req = 1'b1;
        repeat (20) @(negedge clk);
        check_bit(cpu_grant, 1'b0, "grant while painting");
        waited = 0;
        while (exp_q.size() > 0 && waited < 20000) begin
            @(negedge clk);
            waited++;
        end
        check_bit(exp_q.size() == 0, 1'b1, "three lines streamed");
        check_bit(underrun, 1'b0, "underrun");
        check_bit(hsync_n & vsync_n, 1'b1, "syncs inactive");
        $display("test paint_three_lines done");
        tally_and_finish();
    end
endmodule
